// file: baseband_pattern_fifo.sv
// Purpose: Pattern buffer playing I/Q words into an upconverter data port
// Assumes: Single 25 MHz clock; the data clock toward the upconverter is an
//          enable derived by a programmable divider, never above 100 MHz
// Notes:   Settings, loading and the rate only change while idle
// Functional notes
// - Never play faster than the rate ceiling
// - Wraparound starts 2048 data-clock refresh interval
// - Transmit enable held low during refresh
// - Fill from random, count, or host words
// - Loop mode replays continuously until stopped
// - Single mode sends one burst then stops
//
// Chosen here: the address map and the Wishbone interface to the registers.
`timescale 1ns/1ns
`default_nettype none
module baseband_pattern_fifo
  import pattern_fifo_pkg::*;
#(
  parameter int unsigned DEPTH = 1024,
  parameter int unsigned REFRESH = REFRESH_CYCLES
) (
  input  wire logic                 clk_i,
  input  wire logic                 rst_i,
  input  wire logic                 wb_cyc_i,
  input  wire logic                 wb_stb_i,
  input  wire logic                 wb_we_i,
  input  wire logic [7:0]           wb_adr_i,
  input  wire logic [3:0]           wb_sel_i,
  input  wire logic [31:0]          wb_dat_i,
  output logic      [31:0]          wb_dat_o,
  output logic                      wb_ack_o,
  output logic                      parallel_data_clock_o,
  output logic                      tx_enable_o,
  output logic      [WORD_W-1:0]    sample_o,
  output logic                      dsp_serial_input_format_o,
  output logic                      lsb_first_o
);
  import pattern_fifo_pkg::*;

  localparam int unsigned AW = $clog2(DEPTH);
  localparam int unsigned RW = $clog2(REFRESH + 1);
  // Divider ratio floor so the data clock never passes the ceiling
  localparam int unsigned MIN_DIV = (CLK_HZ + MAX_RATE_HZ - 1) / MAX_RATE_HZ;

  initial begin
    if (DEPTH < 2 || (1 << AW) != DEPTH || DEPTH > DEPTH_DEFAULT)
      $error("DEPTH must be a power of two between 2 and 262144");
    if (REFRESH < 1)
      $error("REFRESH must be at least one");
    // Host words are stored whole, so the bus and sample widths must agree
    if (WORD_W != 32)
      $error("WORD_W must match the 32-bit register bus");
    // The divider counter is 16 bits wide
    if (MIN_DIV > 65535)
      $error("Clock too fast for the 16-bit data-clock divider");
  end

  // One decode for every control strobe so they agree on the bus qualifiers
  function automatic logic ctrl_pulse(
    input logic        req,
    input logic        we,
    input logic [7:0]  adr,
    input logic [3:0]  sel,
    input logic [31:0] dat,
    input int unsigned bit_pos
  );
    return req && we && adr == ADDR_CTRL && sel[1] && dat[bit_pos];
  endfunction

  // Code 3 folds onto the host source rather than being left undefined
  function automatic fill_src_t src_decode(input logic [1:0] code);
    return (code == 2'b11) ? SRC_HOST : fill_src_t'(code);
  endfunction

  logic [WORD_W-1:0] mem [DEPTH];
  logic              loop_r;
  fill_src_t         src_r;
  logic              dsp_fmt_r;
  logic              lsb1st_r;
  logic [15:0]       rate_r;
  logic [AW-1:0]     wr_addr_r;
  logic [AW:0]       count_r;
  logic              filling_r;
  logic [31:0]       prbs_r;
  logic [AW-1:0]     rd_addr_r;
  logic [RW-1:0]     refresh_r;
  logic [15:0]       div_r;
  logic              tick;
  play_state_t       state_r;
  logic              start_req;
  logic              stop_req;
  logic              fill_req;
  logic              host_wr;
  logic              bus_req;
  fill_src_t         fill_src;

  assign bus_req   = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign start_req = ctrl_pulse(bus_req, wb_we_i, wb_adr_i, wb_sel_i, wb_dat_i,
                                CTRL_START_BIT);
  assign stop_req  = ctrl_pulse(bus_req, wb_we_i, wb_adr_i, wb_sel_i, wb_dat_i,
                                CTRL_STOP_BIT);
  assign fill_req  = ctrl_pulse(bus_req, wb_we_i, wb_adr_i, wb_sel_i, wb_dat_i,
                                CTRL_FILL_BIT);
  // A fill written together with a new source must use that new source
  assign fill_src  = wb_sel_i[0] ? src_decode(wb_dat_i[CTRL_SRC_LSB +: 2]) : src_r;
  assign host_wr   = bus_req && wb_we_i && wb_adr_i == ADDR_DATA && (&wb_sel_i)
                     && state_r == ST_IDLE && !filling_r;

  // Bus answers every access one cycle after it is seen
  always_ff @(posedge clk_i) begin
    if (rst_i)
      wb_ack_o <= 1'b0;
    else
      wb_ack_o <= bus_req;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_dat_o <= 32'h0000_0000;
    end else if (bus_req && !wb_we_i) begin
      unique case (wb_adr_i)
        ADDR_CTRL:   wb_dat_o <= {27'h000_0000, lsb1st_r, dsp_fmt_r, src_r, loop_r};
        ADDR_STATUS: wb_dat_o <= {29'h0000_0000, filling_r,
                                  state_r == ST_REFRESH, state_r != ST_IDLE};
        ADDR_COUNT:  wb_dat_o <= 32'(count_r);
        ADDR_RATE:   wb_dat_o <= {16'h0000, rate_r};
        default:     wb_dat_o <= 32'h0000_0000;
      endcase
    end
  end

  // Settings only change while idle so a running pattern stays coherent
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      loop_r    <= 1'b0;
      src_r     <= SRC_RANDOM;
      dsp_fmt_r <= 1'b0;
      lsb1st_r  <= 1'b0;
      rate_r    <= RATE_RESET;
    end else if (bus_req && wb_we_i && state_r == ST_IDLE) begin
      if (wb_adr_i == ADDR_CTRL && wb_sel_i[0]) begin
        loop_r    <= wb_dat_i[CTRL_LOOP_BIT];
        src_r     <= src_decode(wb_dat_i[CTRL_SRC_LSB +: 2]);
        dsp_fmt_r <= wb_dat_i[CTRL_DSP_FMT_BIT];
        lsb1st_r  <= wb_dat_i[CTRL_LSB1ST_BIT];
      end
      if (wb_adr_i == ADDR_RATE && (&wb_sel_i[1:0]))
        rate_r <= wb_dat_i[15:0];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dsp_serial_input_format_o <= 1'b0;
      lsb_first_o               <= 1'b0;
    end else begin
      dsp_serial_input_format_o <= dsp_fmt_r;
      lsb_first_o               <= lsb1st_r;
    end
  end

  // Loading: generated sources sweep the whole depth, host words append
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wr_addr_r <= '0;
      count_r   <= '0;
      filling_r <= 1'b0;
      prbs_r    <= PRBS_SEED;
    end else if (filling_r) begin
      mem[wr_addr_r] <= (src_r == SRC_COUNT) ? WORD_W'(wr_addr_r) : prbs_r;
      prbs_r         <= {prbs_r[30:0], prbs_r[31] ^ prbs_r[21] ^ prbs_r[1] ^ prbs_r[0]};
      wr_addr_r      <= wr_addr_r + 1'b1;
      if (wr_addr_r == AW'(DEPTH - 1)) begin
        filling_r <= 1'b0;
        count_r   <= (AW + 1)'(DEPTH);
      end
    end else if (fill_req && state_r == ST_IDLE) begin
      wr_addr_r <= '0;
      count_r   <= '0;
      filling_r <= (fill_src != SRC_HOST);
    end else if (host_wr && src_r == SRC_HOST && count_r != (AW + 1)'(DEPTH)) begin
      mem[wr_addr_r] <= wb_dat_i;
      wr_addr_r      <= wr_addr_r + 1'b1;
      count_r        <= count_r + 1'b1;
    end
  end

  // Data clock enable; the ratio is clamped up so the rate ceiling holds
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      div_r <= '0;
      tick  <= 1'b0;
    end else if (div_r + 16'd1 >= rate_r && div_r + 16'd1 >= 16'(MIN_DIV)) begin
      div_r <= '0;
      tick  <= 1'b1;
    end else begin
      div_r <= div_r + 16'd1;
      tick  <= 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i)
      parallel_data_clock_o <= 1'b0;
    else
      parallel_data_clock_o <= tick;
  end

  // Play-out sequencer
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_r     <= ST_IDLE;
      rd_addr_r   <= '0;
      refresh_r   <= '0;
      tx_enable_o <= 1'b0;
      sample_o    <= '0;
    end else if (stop_req) begin
      state_r     <= ST_IDLE;
      tx_enable_o <= 1'b0;
    end else begin
      unique case (state_r)
        ST_IDLE: begin
          // The last burst word stands its full data-clock period
          if (tick)
            tx_enable_o <= 1'b0;
          if (start_req && !filling_r && count_r != '0) begin
            state_r   <= ST_PLAY;
            rd_addr_r <= '0;
          end
        end
        ST_PLAY: begin
          if (tick) begin
            sample_o    <= mem[rd_addr_r];
            tx_enable_o <= 1'b1;
            if ((AW + 1)'(rd_addr_r) == count_r - 1'b1) begin
              rd_addr_r <= '0;
              refresh_r <= '0;
              state_r   <= loop_r ? ST_REFRESH : ST_IDLE;
            end else begin
              rd_addr_r <= rd_addr_r + 1'b1;
            end
          end
        end
        ST_REFRESH: begin
          if (tick) begin
            tx_enable_o <= 1'b0;
            if (refresh_r == RW'(REFRESH - 1))
              state_r <= ST_PLAY;
            refresh_r <= refresh_r + 1'b1;
          end
        end
        default: state_r <= ST_IDLE;
      endcase
    end
  end

  // Single burst: the last word stays valid for its data-clock period
  // then enable falls in idle at the next tick
endmodule : baseband_pattern_fifo
`default_nettype wire

// file: pattern_fifo_pkg.sv
// Purpose: Constants for the baseband pattern buffer
// Assumes: 25 MHz system clock, classic Wishbone register access
// Notes:   Offsets are byte addresses of 32-bit words
package pattern_fifo_pkg;
  localparam int unsigned CLK_HZ          = 25_000_000;
  localparam int unsigned MAX_RATE_HZ     = 100_000_000;
  localparam int unsigned REFRESH_CYCLES  = 2048;
  localparam int unsigned DEPTH_DEFAULT   = 262144;
  localparam int unsigned WORD_W          = 32;
  localparam logic [7:0] ADDR_CTRL   = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_LOAD   = 8'h08;
  localparam logic [7:0] ADDR_DATA   = 8'h0C;
  localparam logic [7:0] ADDR_COUNT  = 8'h10;
  localparam logic [7:0] ADDR_RATE   = 8'h14;
  // Control register fields
  localparam int unsigned CTRL_LOOP_BIT    = 0;
  localparam int unsigned CTRL_SRC_LSB     = 1;
  localparam int unsigned CTRL_DSP_FMT_BIT = 3;
  localparam int unsigned CTRL_LSB1ST_BIT  = 4;
  localparam int unsigned CTRL_START_BIT   = 8;
  localparam int unsigned CTRL_STOP_BIT    = 9;
  localparam int unsigned CTRL_FILL_BIT    = 10;
  // Status register fields
  localparam int unsigned STAT_BUSY_BIT    = 0;
  localparam int unsigned STAT_REFRESH_BIT = 1;
  localparam int unsigned STAT_FILL_BIT    = 2;
  localparam logic [31:0] PRBS_SEED  = 32'h1ACE_B00C;
  localparam logic [15:0] RATE_RESET = 16'h0000;
  typedef enum logic [1:0] {
    SRC_RANDOM = 2'b00,
    SRC_COUNT  = 2'b01,
    SRC_HOST   = 2'b10
  } fill_src_t;
  typedef enum logic [1:0] {
    ST_IDLE    = 2'b00,
    ST_PLAY    = 2'b01,
    ST_REFRESH = 2'b11
  } play_state_t;
endpackage : pattern_fifo_pkg

// file: bpf_asserts.sv
// Purpose: Port checks for the pattern buffer
// Assumes: Bound to baseband_pattern_fifo
// Notes: Ack comes one cycle after a request
`timescale 1ns/1ns
`default_nettype none
module bpf_asserts (
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_we_i,
  input wire logic [7:0]  wb_adr_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic        wb_ack_o,
  input wire logic        parallel_data_clock_o,
  input wire logic        tx_enable_o,
  input wire logic [31:0] sample_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  sequence req_s; wb_cyc_i && wb_stb_i && !wb_ack_o; endsequence
  sequence tick_s; parallel_data_clock_o || $past(parallel_data_clock_o); endsequence
  AST_ACK_NEXT: assert property (req_s |=> wb_ack_o) else $error("ack late");
  AST_ACK_PULSE: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack held");
  AST_ACK_CAUSE: assert property ($rose(wb_ack_o) |-> $past(wb_cyc_i && wb_stb_i))
    else $error("ack without request");
  AST_DAT_HOLD: assert property ($changed(wb_dat_o) |-> wb_ack_o) else $error("data moved");
  AST_UNMAPPED: assert property (wb_ack_o && !$past(wb_we_i) && $past(wb_adr_i) == 8'h20
    |-> wb_dat_o == 32'h0000_0000) else $error("unmapped read not zero");
  AST_SAMPLE_TICK: assert property ($changed(sample_o) && tx_enable_o |-> tick_s)
    else $error("word off tick");
  AST_TXEN_TICK: assert property ($rose(tx_enable_o) |-> tick_s) else $error("enable off tick");
  AST_RST_QUIET: assert property ($fell(rst_i) |-> !tx_enable_o && !wb_ack_o)
    else $error("busy after reset");
endmodule // bpf_asserts
`default_nettype wire

// file: pattern_sink.sv
// Purpose: Upconverter data input model
// Assumes: Words are taken on data-clock ticks
// Notes: Gap counts ticks with enable low before each restart
`timescale 1ns/1ns
`default_nettype none
module pattern_sink (
  input wire logic        clk_i,
  input wire logic        tick_i,
  input wire logic        tx_enable_i,
  input wire logic [31:0] sample_i
);
  logic [31:0] q[$];
  int          gaps[$];
  int          gap_r = 0;
  logic        en_r = 1'b0;
  // Accepts raw words only, never faster than the tick
  always @(posedge clk_i) begin
    if (tick_i && tx_enable_i) q.push_back(sample_i);
    if (tick_i && !tx_enable_i) gap_r++;
    if (tx_enable_i && !en_r) begin
      gaps.push_back(gap_r);
      gap_r = 0;
    end
    en_r = tx_enable_i;
  end
endmodule // pattern_sink
`default_nettype wire

// file: tb.sv
// Purpose: Self-checking bench for the pattern buffer
// Assumes: DEPTH 16, REFRESH 8, divider at reset value until the slow burst sets the rate to 3
// Notes: Played words are checked against a queue model
`timescale 1ns/1ns
`default_nettype none
module tb;
  import pattern_fifo_pkg::*;
  localparam int DP = 16;
  localparam int RF = 8;
  logic        clk_i = 0, rst_i = 1, cyc = 0, we = 0;
  logic [7:0]  adr = 0;
  logic [31:0] wdat = 0, rd, seed = 32'hf834_4cba;
  wire logic [31:0] dat_o, smp;
  wire logic   ack, tick, txen, dsp, lsb;
  int          miscompares = 0, samples_checked = 0, cyc_n = 0, n;
  logic [31:0] mdl[$];
  baseband_pattern_fifo #(.DEPTH(DP), .REFRESH(RF)) u_baseband_pattern_fifo (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(dat_o), .wb_ack_o(ack),
    .parallel_data_clock_o(tick), .tx_enable_o(txen), .sample_o(smp),
    .dsp_serial_input_format_o(dsp), .lsb_first_o(lsb));
  pattern_sink u_pattern_sink (.clk_i(clk_i), .tick_i(tick), .tx_enable_i(txen),
    .sample_i(smp));
  initial forever #20 clk_i = ~clk_i;
  always @(posedge clk_i) begin
    cyc_n++;
    if (cyc_n > 20000) begin
      miscompares++;
      complete_run();
    end
  end
  function automatic logic [31:0] xs(input logic [31:0] x);
    x ^= x << 13;
    x ^= x >> 17;
    return x ^ (x << 5);
  endfunction
  task automatic complete_run();
    $display("checks %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic cmp(input logic [31:0] g, input logic [31:0] e);
    samples_checked++;
    if (g !== e) begin
      miscompares++;
      $display("unexpected at %0t got %h exp %h", $time, g, e);
    end
  endtask
  // Classic cycle: hold everything until ack is sampled high
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    cyc <= 1;
    we <= w;
    adr <= a;
    wdat <= d;
    do @(posedge clk_i); while (ack !== 1'b1);
    rd = dat_o;
    cyc <= 0;
  endtask
  task automatic idle();
    n = 0;
    do wb(0, ADDR_STATUS, 0); while (rd[2:0] !== 3'b000 && ++n < 100);
  endtask
  task automatic burst(input logic [31:0] ctl);
    u_pattern_sink.q.delete();
    wb(1, ADDR_CTRL, ctl);
    idle();
    cmp(32'(u_pattern_sink.q.size()), 32'(mdl.size()));
    foreach (mdl[i]) cmp(u_pattern_sink.q[i], mdl[i]);
  endtask
  initial begin
    repeat (16) @(posedge clk_i);
    rst_i <= 0;
    // Random, host, then count fill; host fill restarts at zero
    for (int s = 0; s < 3; s++) begin
      wb(1, ADDR_CTRL, 32'h0000_0400 | 32'((s * 2) % 3) << 1);
      idle();
      wb(0, ADDR_COUNT, 0);
      cmp(rd, s == 1 ? 32'h0000_0000 : 32'(DP));
    end
    for (int i = 0; i < DP; i++) mdl.push_back(32'(i));
    burst(32'h0000_0102);
    $display("done: fill sources");
    mdl.delete();
    wb(1, ADDR_CTRL, 32'h0000_0404);
    repeat (4) begin
      seed = xs(seed);
      mdl.push_back(seed);
      wb(1, ADDR_DATA, seed);
    end
    wb(0, ADDR_COUNT, 0);
    cmp(rd, 32'h0000_0004);
    burst(32'h0000_0104);
    $display("done: host burst");
    wb(1, ADDR_RATE, 32'h0000_0003);
    wb(0, ADDR_RATE, 0);
    cmp(rd, 32'h0000_0003);
    burst(32'h0000_0104);
    $display("done: slow burst");
    u_pattern_sink.q.delete();
    n = u_pattern_sink.gaps.size() + 2;
    wb(1, ADDR_CTRL, 32'h0000_0105);
    for (int i = 0; i < 500 && u_pattern_sink.gaps.size() < n; i++) @(posedge clk_i);
    wb(1, ADDR_CTRL, 32'h0000_0204);
    @(posedge clk_i);
    cmp(32'(txen), 32'h0);
    cmp(32'(u_pattern_sink.gaps[$]), 32'(RF));
    cmp(32'(u_pattern_sink.q.size() > mdl.size()), 32'h1);
    foreach (u_pattern_sink.q[i]) cmp(u_pattern_sink.q[i], mdl[i % mdl.size()]);
    $display("done: loop");
    wb(0, 8'h20, 0);
    cmp(rd, 32'h0000_0000);
    wb(1, ADDR_CTRL, 32'h0000_0018);
    @(posedge clk_i);
    cmp(32'({dsp, lsb}), 32'h3);
    $display("done: registers");
    complete_run();
  end
endmodule // tb
bind baseband_pattern_fifo bpf_asserts u_bpf_asserts (.clk_i(clk_i), .rst_i(rst_i),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
  .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .parallel_data_clock_o(parallel_data_clock_o),
  .tx_enable_o(tx_enable_o), .sample_o(sample_o));
`default_nettype wire
